// ---- design/lvm_params.svh ----
// Constants for the LED voltage converter monitor block.
// Functional notes
// - The 4-bit converted LED voltage sits in bits [3:0] of the monitor register.
// - Each result is the higher of the two LED output voltages measured to ground.
// - Bit 4 enables manual conversion mode when one and disables it when zero, its default.
// - Automatic conversions keep running while manual mode is enabled.
// - A flash pulse start launches one automatic conversion unless one is already pending or running.
// - Bit 5 shuts the converter down so nothing converts; zero, the default, enables it.
// - Bit 6 is a read-only end-of-conversion flag, zero by default and while converting, except after a start launched in the cycle a conversion completes.
// - A read of the monitor register clears the end-of-conversion flag unless a conversion completes in the same cycle.
`ifndef LVM_PARAMS_SVH
`define LVM_PARAMS_SVH

`define LVM_DATA_W 8
`define LVM_RESULT_W 4
`define LVM_RESULT_MSB 3
`define LVM_RESULT_LSB 0
`define LVM_MANUAL_BIT 4
`define LVM_SHDN_BIT 5
`define LVM_EOC_BIT 6
`define LVM_RESULT_RESET 4'h0
`define LVM_REG_RESET 8'h00
`define LVM_CLK_PERIOD_PS 5000
`define LVM_CONV_TIME_PS 2000000
// Least time, so the cycle count rounds up.
`define LVM_CONV_CYCLES ((`LVM_CONV_TIME_PS + `LVM_CLK_PERIOD_PS - 1) / `LVM_CLK_PERIOD_PS)
`define LVM_CNT_W 16

`endif

// ---- design/lvm_pkg.sv ----
// Types shared by the LED voltage converter monitor block.
package lvm_pkg;
  typedef enum logic [0:0] {
    LVM_IDLE,
    LVM_CONV
  } lvm_state_e;
endpackage

// ---- design/lvm_conv_if.sv ----
// Signals between the register side and the conversion sequencer.
`timescale 1ns/1ps
`include "lvm_params.svh"
interface lvm_conv_if;
  logic start;
  logic abort;
  logic busy;
  logic done;
  logic [`LVM_RESULT_W-1:0] result;
  modport ctrl (output start, output abort, input busy, input done, input result);
  modport conv (input start, input abort, output busy, output done, output result);
endinterface

// ---- design/lvm_converter.sv ----
// Conversion sequencer: samples the two LED voltages and keeps the higher.
`timescale 1ns/1ps
`include "lvm_params.svh"
module lvm_converter #(
  parameter int CONV_CYCLES = `LVM_CONV_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [`LVM_RESULT_W-1:0] led_one_voltage_in,
  input wire logic [`LVM_RESULT_W-1:0] led_two_voltage_in,
  lvm_conv_if.conv cv
);
  typedef struct packed {
    lvm_pkg::lvm_state_e state;
    logic [`LVM_CNT_W-1:0] cnt;
    logic [`LVM_RESULT_W-1:0] result;
    logic done;
  } lvm_conv_s;

  localparam logic [`LVM_CNT_W-1:0] LAST = `LVM_CNT_W'(CONV_CYCLES - 1);

  lvm_conv_s st_reg;
  lvm_conv_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // A conversion not aborted holds for its full time, then latches the larger input.
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    unique case (st_reg.state)
      lvm_pkg::LVM_IDLE: begin
        if (cv.start) begin
          st_next.state = lvm_pkg::LVM_CONV;
          st_next.cnt = '0;
        end
      end
      lvm_pkg::LVM_CONV: begin
        if (cv.abort) begin
          st_next.state = lvm_pkg::LVM_IDLE;
        end else if (st_reg.cnt == LAST) begin
          st_next.state = lvm_pkg::LVM_IDLE;
          st_next.done = 1'b1;
          // Sampling at the end means the higher voltage at that moment wins.
          if (led_one_voltage_in >= led_two_voltage_in) begin
            st_next.result = led_one_voltage_in;
          end else begin
            st_next.result = led_two_voltage_in;
          end
        end else begin
          st_next.cnt = st_reg.cnt + `LVM_CNT_W'(1);
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg.state <= lvm_pkg::LVM_IDLE;
      st_reg.cnt <= '0;
      st_reg.result <= `LVM_RESULT_RESET;
      st_reg.done <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cv.busy = (st_reg.state == lvm_pkg::LVM_CONV);
  assign cv.done = st_reg.done;
  assign cv.result = st_reg.result;
endmodule // lvm_converter

// ---- design/lvm_top.sv ----
// LED voltage monitor register and converter control.
`timescale 1ns/1ps
`include "lvm_params.svh"
module lvm_top #(
  parameter int CONV_CYCLES = `LVM_CONV_CYCLES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [`LVM_DATA_W-1:0] reg_wdata_in,
  input wire logic flash_start_in,
  input wire logic [`LVM_RESULT_W-1:0] led_one_voltage_in,
  input wire logic [`LVM_RESULT_W-1:0] led_two_voltage_in,
  output logic [`LVM_DATA_W-1:0] reg_rdata_out,
  output logic conv_busy_out
);
  typedef struct packed {
    logic manual;
    logic shdn;
    logic eoc;
    logic [`LVM_DATA_W-1:0] rdata;
    logic busy;
    logic start;
    logic abort;
  } lvm_top_s;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  lvm_top_s st_reg;
  lvm_top_s st_next;
  lvm_conv_if cv ();

  ////////////////////////////////////////////////////////////////////////////
  // Reset is released through two flops so the register and converter flops leave reset together.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register behaviour and conversion requests.
  always_comb begin
    logic shdn_now;
    logic req;
    shdn_now = st_reg.shdn;
    req = 1'b0;
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.abort = 1'b0;
    st_next.busy = cv.busy;
    // Bit 7 and the read-only fields are simply not stored.
    if (reg_wr_in) begin
      st_next.manual = reg_wdata_in[`LVM_MANUAL_BIT];
      st_next.shdn = reg_wdata_in[`LVM_SHDN_BIT];
      shdn_now = reg_wdata_in[`LVM_SHDN_BIT];
      // A write with manual mode set asks for one manual conversion.
      req = reg_wdata_in[`LVM_MANUAL_BIT];
    end
    // Flash starts convert whether or not manual mode is on.
    if (flash_start_in) begin
      req = 1'b1;
    end
    // Requests while busy merge into the running conversion.
    if (req && !shdn_now && !cv.busy && !st_reg.start) begin
      st_next.start = 1'b1;
      st_next.eoc = 1'b0;
    end
    // Shutdown stops a conversion in flight so no stale result lands.
    st_next.abort = shdn_now;
    // Read returns the register and clears the flag.
    if (reg_rd_in) begin
      st_next.rdata = '0;
      st_next.rdata[`LVM_RESULT_MSB:`LVM_RESULT_LSB] = cv.result;
      st_next.rdata[`LVM_MANUAL_BIT] = st_reg.manual;
      st_next.rdata[`LVM_SHDN_BIT] = st_reg.shdn;
      st_next.rdata[`LVM_EOC_BIT] = st_reg.eoc;
      st_next.eoc = 1'b0;
    end
    // Completion wins over a clearing read in the same cycle.
    if (cv.done) begin
      st_next.eoc = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.manual <= 1'b0;
      st_reg.shdn <= 1'b0;
      st_reg.eoc <= 1'b0;
      st_reg.rdata <= `LVM_REG_RESET;
      st_reg.busy <= 1'b0;
      st_reg.start <= 1'b0;
      st_reg.abort <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cv.start = st_reg.start;
  assign cv.abort = st_reg.abort;
  assign reg_rdata_out = st_reg.rdata;
  assign conv_busy_out = st_reg.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.
  lvm_converter #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .led_one_voltage_in(led_one_voltage_in),
    .led_two_voltage_in(led_two_voltage_in),
    .cv(cv)
  );
endmodule // lvm_top

// ---- testbench/lvm_properties.sv ----
// Port-level checks of the LED voltage monitor register.
`timescale 1ns/1ps
`include "lvm_params.svh"
module lvm_properties #(
  parameter int CONV_CYCLES = `LVM_CONV_CYCLES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic flash_start_in,
  input wire logic [3:0] led_one_voltage_in,
  input wire logic [3:0] led_two_voltage_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic conv_busy_out
);
  localparam int LIM = CONV_CYCLES + 4;
  logic sd_reg;
  logic req;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Shadow of the shutdown bit, so refused requests are not expected to start.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) sd_reg <= 1'h0;
    else if (reg_wr_in) sd_reg <= reg_wdata_in[5];
  end
  // Any request that may launch a conversion.
  assign req = flash_start_in || (reg_wr_in && reg_wdata_in[4]);
  ////////////////////////////////////////////////////////////////////////
  a_spare_zero: assert property (reg_rdata_out[7] == 1'h0)
    else $error("spare bit set");
  a_rdata_holds: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved");
  a_mode_back: assert property (reg_wr_in ##1 reg_rd_in
    |=> reg_rdata_out[5:4] == $past(reg_wdata_in[5:4], 2)) else $error("mode bits");
  a_shdn_abort: assert property (reg_wr_in && reg_wdata_in[5] |-> ##3 !conv_busy_out)
    else $error("busy under shutdown");
  a_req_starts: assert property (req && !sd_reg && !conv_busy_out && !$past(req)
    && !$past(req, 2) && !(reg_wr_in && reg_wdata_in[5]) |-> ##3 conv_busy_out)
    else $error("no start");
  a_busy_ends: assert property ($rose(conv_busy_out) |-> ##[1:LIM] !conv_busy_out)
    else $error("busy stuck");
  // A shutdown two edges before the fall means the run was aborted, so no flag is due.
  a_eoc_sets: assert property ($fell(conv_busy_out) && !sd_reg && !$past(sd_reg, 2)
    && !req && !reg_rd_in ##1 reg_rd_in |=> reg_rdata_out[6]) else $error("eoc missing");
  // Busy low throughout means no completion can set the flag between the two reads.
  a_read_clears: assert property (reg_rd_in && !conv_busy_out ##1 (!conv_busy_out) [*2]
    ##1 reg_rd_in && !conv_busy_out |=> !reg_rdata_out[6]) else $error("eoc not cleared");
endmodule // lvm_properties
bind lvm_top lvm_properties #(.CONV_CYCLES(CONV_CYCLES)) i_props (.*);

// ---- testbench/lvm_top_test.sv ----
// Self-checking bench for the LED voltage monitor register.
`timescale 1ns/1ps
module lvm_top_test;
  logic clk_in = 0, rstn_in = 0, reg_wr_in = 0, reg_rd_in = 0, flash_start_in = 0;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
  logic [3:0] led_one_voltage_in = 4'h0, led_two_voltage_in = 4'h0;
  logic conv_busy_out, man = 0;
  logic [31:0] seed = 32'h86D30FC0;
  int fail_count = 0, total_checks = 0;
  always #2.5 clk_in = ~clk_in;
  lvm_top #(.CONV_CYCLES(4)) i_dut (.*);
  ////////////////////////////////////////////////////////////////////////
  // Summary and verdict; also the exit of every expired wait.
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One strobe cycle; the idle edge after it keeps strobes from colliding.
  task automatic op(input logic wr, input logic rd, input logic fl, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= wr; reg_rd_in <= rd; flash_start_in <= fl; reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 0; reg_rd_in <= 0; flash_start_in <= 0;
  endtask
  task automatic chk_busy(input logic exp);
    total_checks++;
    if (conv_busy_out !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, conv_busy_out, exp);
    end
  endtask
  task automatic rd(input logic [7:0] exp);
    op(0, 1, 0, 8'h00);
    @(posedge clk_in);
    #1 chk(reg_rdata_out, exp);
  endtask
  task automatic wait_busy(input logic lvl);
    int n = 0;
    while (conv_busy_out !== lvl && n < 50) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n == 50) begin
      fail_count++;
      conclude();
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Expected result code: the higher of the two LED voltages.
  function automatic logic [3:0] hi(input logic [3:0] x, input logic [3:0] y);
    return (x > y) ? x : y;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Random conversions by flash or manual write, then shutdown corners.
  initial begin
    logic [3:0] a, b, r;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1;
    repeat (3) @(posedge clk_in);
    rd(8'h00);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      a = (i == 0) ? 4'hF : seed[3:0];
      b = (i == 1) ? 4'hF : (i == 2) ? a : seed[7:4];
      r = hi(a, b);
      @(posedge clk_in);
      led_one_voltage_in <= a;
      led_two_voltage_in <= b;
      if (seed[17]) begin
        op(1, 0, 0, seed[15:8] & 8'hCF);
        man = 0;
      end
      if (seed[16]) begin
        op(1, 0, 0, seed[15:8] & 8'hDF | 8'h10);
        man = 1;
      end else op(0, 0, 1, 8'h00);
      wait_busy(1);
      wait_busy(0);
      rd({3'h2, man, r});
      rd({3'h0, man, r});
    end
    op(0, 0, 1, 8'h00);
    wait_busy(1);
    op(1, 0, 0, 8'h20);
    wait_busy(0);
    rd({4'h2, r});
    op(0, 0, 1, 8'h00);
    repeat (6) @(posedge clk_in);
    #1 chk_busy(1'b0);
    @(posedge clk_in) begin
      reg_wr_in <= 1;
      reg_wdata_in <= 8'hF0;
    end
    @(posedge clk_in) begin
      reg_wr_in <= 0;
      reg_rd_in <= 1;
    end
    @(posedge clk_in) reg_rd_in <= 0;
    @(posedge clk_in);
    #1 chk(reg_rdata_out, {4'h3, r});
    conclude();
  end
endmodule // lvm_top_test
